/* File: design/flash_command_decoder.sv */
// Command user interface decoder for a multi-partition NOR flash
// Notes on behaviour
// - FFh puts partition into array read
// - 70h puts partition into status read
// - Program or erase issue forces status read
// - 90h puts partition into identifier read
// - 98h gives query data on low byte
// - Error bits cleared only by reset or 50h
// - 40h setup, next write programs that word
// - 10h behaves exactly like 40h
// - Status view refreshes only on CE/OE toggle while busy
// - 30h then D0h enters factory program mode
// - Factory program mode ignores all other commands
// - 20h then D0h erases confirm-address block
// - Bad erase confirm sets bits 5,4, status
// - Busy partition takes only status and suspend
// - B0h suspends; bit 7 plus 2 or 6
// - Suspend holds until resume or reset only
// - D0h anywhere resumes suspended operation
// - Bad code after 60h sets bits 5,4
// - 60h then 01h lock, 2Fh down, D0h unlock
// - C0h then next write programs protection
// - 60h then 03h loads config from address
// - Bad second code after 20h, 60h or 30h reports sequence error
// - Reset: array reads, status 80h, async config
`timescale 1ns/1ns

module flash_command_decoder #(
    parameter int PART_BITS = 3,                          // Partition select address bits
    parameter int NUM_PARTS = 8                           // Number of partitions
) (
    input wire logic clock,                               // 250 MHz clock
    input wire logic rst,                                 // Async reset, active high
    input wire logic clk_en,                              // Freezes all state when low
    input wire logic wr_strobe,                           // One-cycle host write strobe
    input wire flash_cmd_pkg::bus_write_t wr_bus,         // Write address and data
    input wire logic ce_oe_toggle,                        // Pulse on CE or OE toggle
    input wire logic op_done,                             // Pulse: algorithm finished
    input wire logic op_prog_fail,                        // With op_done: program failed
    input wire logic op_erase_fail,                       // With op_done: erase failed
    input wire logic op_vpp_fail,                         // With op_done: supply fault
    input wire logic op_lock_fail,                        // With op_done: block locked
    input wire logic [PART_BITS-1:0] rd_part,             // Partition being read
    output flash_cmd_pkg::read_mode_t rd_mode,            // Read mode of rd_part
    output logic [15:0] status_view,                      // Status as presented on reads
    output logic query_low_only,                          // Only DQ[7:0] carry data
    output flash_cmd_pkg::op_req_t op_req,                // Operation request
    output logic op_start,                                // Pulse: start op_req
    output logic op_suspend,                              // Level: algorithm suspended
    output flash_cmd_pkg::lock_act_t lock_act,            // Lock action
    output logic [22:0] lock_addr,                        // Block address of lock action
    output logic lock_start,                              // Pulse: apply lock action
    output logic [15:0] config_out,                       // Configuration register
    output logic efp_mode                                 // Factory program mode active
);

    // ------------------------------------------------------------
    // State declarations
    // ------------------------------------------------------------
    flash_cmd_pkg::read_mode_t mode_reg [NUM_PARTS];      // Read mode per partition
    flash_cmd_pkg::read_mode_t mode_next [NUM_PARTS];
    flash_cmd_pkg::seq_state_t seq_reg, seq_next;         // Two-cycle sequence state
    flash_cmd_pkg::wsm_state_t wsm_reg, wsm_next;         // Algorithm activity
    logic [PART_BITS-1:0] busy_part_reg, busy_part_next;  // Partition running an op
    logic susp_erase_reg, susp_erase_next;                // Current op is an erase
    logic [7:0] status_reg, status_next;                  // Status register
    logic [7:0] view_reg, view_next;                      // Snapshot shown on reads
    logic [15:0] config_reg, config_next;                 // Configuration register
    flash_cmd_pkg::op_req_t req_reg, req_next;            // Latched request
    logic start_reg, start_next;                          // Start pulse
    flash_cmd_pkg::lock_act_t lact_reg, lact_next;        // Lock action
    logic [22:0] laddr_reg, laddr_next;                   // Lock address
    logic lstart_reg, lstart_next;                        // Lock pulse

    // Decode of the partition addressed by a write
    function automatic logic [PART_BITS-1:0] part_of(input logic [22:0] a);
        part_of = a[22 -: PART_BITS];
    endfunction

    // Codes that start a two-cycle sequence
    function automatic logic is_setup(input logic [7:0] c);
        is_setup = (c == flash_cmd_pkg::CMD_PROG_SETUP) || (c == flash_cmd_pkg::CMD_PROG_ALT)
            || (c == flash_cmd_pkg::CMD_ERASE_SETUP) || (c == flash_cmd_pkg::CMD_LOCK_SETUP)
            || (c == flash_cmd_pkg::CMD_EFP_SETUP) || (c == flash_cmd_pkg::CMD_PROT_SETUP);
    endfunction

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Computes the next state of every group from one write cycle
    always_comb begin
        logic [7:0] code;
        logic [PART_BITS-1:0] wp;
        logic seq_err;
        logic done;
        code = wr_bus.data[7:0];
        wp = part_of(wr_bus.addr);
        seq_err = 1'b0;
        done = op_done && wsm_reg == flash_cmd_pkg::WSM_BUSY;
        mode_next = mode_reg;
        seq_next = seq_reg;
        wsm_next = wsm_reg;
        busy_part_next = busy_part_reg;
        susp_erase_next = susp_erase_reg;
        status_next = status_reg;
        view_next = view_reg;
        config_next = config_reg;
        req_next = req_reg;
        start_next = 1'b0;
        lact_next = lact_reg;
        laddr_next = laddr_reg;
        lstart_next = 1'b0;
        // Algorithm completion sets error bits, never clears them
        if (done) begin
            wsm_next = flash_cmd_pkg::WSM_IDLE;
            status_next[flash_cmd_pkg::SR_READY] = 1'b1;
            status_next[flash_cmd_pkg::SR_PROG_ERR] = status_reg[flash_cmd_pkg::SR_PROG_ERR]
                | op_prog_fail;
            status_next[flash_cmd_pkg::SR_ERASE_ERR] = status_reg[flash_cmd_pkg::SR_ERASE_ERR]
                | op_erase_fail;
            status_next[flash_cmd_pkg::SR_VPP_ERR] = status_reg[flash_cmd_pkg::SR_VPP_ERR]
                | op_vpp_fail;
            status_next[flash_cmd_pkg::SR_LOCK_ERR] = status_reg[flash_cmd_pkg::SR_LOCK_ERR]
                | op_lock_fail;
            if (seq_reg == flash_cmd_pkg::SEQ_EFP_RUN && !wr_strobe) begin
                seq_next = flash_cmd_pkg::SEQ_IDLE;
            end
        end
        if (wr_strobe) begin
            unique case (seq_reg)
                // Second cycle of word program: capture and start
                flash_cmd_pkg::SEQ_PROG: begin
                    req_next = '{flash_cmd_pkg::OP_PROGRAM, wr_bus.addr, wr_bus.data};
                    start_next = 1'b1;
                    seq_next = flash_cmd_pkg::SEQ_IDLE;
                end
                // Second cycle of protection program
                flash_cmd_pkg::SEQ_PROT: begin
                    req_next = '{flash_cmd_pkg::OP_PROT, wr_bus.addr, wr_bus.data};
                    start_next = 1'b1;
                    seq_next = flash_cmd_pkg::SEQ_IDLE;
                end
                // Erase confirm or sequence error
                flash_cmd_pkg::SEQ_ERASE: begin
                    seq_next = flash_cmd_pkg::SEQ_IDLE;
                    if (code == flash_cmd_pkg::CMD_CONFIRM) begin
                        req_next = '{flash_cmd_pkg::OP_ERASE, wr_bus.addr, wr_bus.data};
                        start_next = 1'b1;
                    end else begin
                        seq_err = 1'b1;
                    end
                end
                // Second code decides lock versus configuration
                flash_cmd_pkg::SEQ_LOCK: begin
                    seq_next = flash_cmd_pkg::SEQ_IDLE;
                    laddr_next = wr_bus.addr;
                    if (code == flash_cmd_pkg::CMD_LOCK) begin
                        lact_next = flash_cmd_pkg::LK_LOCK;
                        lstart_next = 1'b1;
                    end else if (code == flash_cmd_pkg::CMD_LOCK_DOWN) begin
                        lact_next = flash_cmd_pkg::LK_DOWN;
                        lstart_next = 1'b1;
                    end else if (code == flash_cmd_pkg::CMD_CONFIRM) begin
                        lact_next = flash_cmd_pkg::LK_UNLOCK;
                        lstart_next = 1'b1;
                    end else if (code == flash_cmd_pkg::CMD_SET_CONFIG) begin
                        config_next = wr_bus.addr[15:0];
                        mode_next[wp] = flash_cmd_pkg::RD_ARRAY;
                    end else begin
                        seq_err = 1'b1;
                    end
                end
                // Factory program confirm
                flash_cmd_pkg::SEQ_EFP: begin
                    if (code == flash_cmd_pkg::CMD_CONFIRM) begin
                        req_next = '{flash_cmd_pkg::OP_EFP, wr_bus.addr, wr_bus.data};
                        start_next = 1'b1;
                        seq_next = flash_cmd_pkg::SEQ_EFP_RUN;
                    end else begin
                        seq_err = 1'b1;
                        seq_next = flash_cmd_pkg::SEQ_IDLE;
                    end
                end
                // Factory program: every write is data, codes ignored
                flash_cmd_pkg::SEQ_EFP_RUN: begin
                    req_next = '{flash_cmd_pkg::OP_EFP_DATA, wr_bus.addr, wr_bus.data};
                    start_next = 1'b1;
                end
                // Single-cycle commands and setups
                flash_cmd_pkg::SEQ_IDLE: begin
                    if (code == flash_cmd_pkg::CMD_SUSPEND
                            && wsm_reg == flash_cmd_pkg::WSM_BUSY) begin
                        wsm_next = flash_cmd_pkg::WSM_SUSP;
                        status_next[flash_cmd_pkg::SR_READY] = 1'b1;
                        status_next[flash_cmd_pkg::SR_ERASE_SUSP] = susp_erase_reg;
                        status_next[flash_cmd_pkg::SR_PROG_SUSP] = !susp_erase_reg;
                    end else if (code == flash_cmd_pkg::CMD_CONFIRM
                            && wsm_reg == flash_cmd_pkg::WSM_SUSP) begin
                        wsm_next = flash_cmd_pkg::WSM_BUSY;
                        status_next[flash_cmd_pkg::SR_READY] = 1'b0;
                        status_next[flash_cmd_pkg::SR_ERASE_SUSP] = 1'b0;
                        status_next[flash_cmd_pkg::SR_PROG_SUSP] = 1'b0;
                    end else if (code == flash_cmd_pkg::CMD_READ_STATUS) begin
                        mode_next[wp] = flash_cmd_pkg::RD_STATUS;
                    end else if (wsm_reg == flash_cmd_pkg::WSM_BUSY && wp == busy_part_reg) begin
                        mode_next[wp] = mode_reg[wp];
                    end else if (code == flash_cmd_pkg::CMD_READ_ARRAY) begin
                        mode_next[wp] = flash_cmd_pkg::RD_ARRAY;
                    end else if (code == flash_cmd_pkg::CMD_READ_ID) begin
                        mode_next[wp] = flash_cmd_pkg::RD_ID;
                    end else if (code == flash_cmd_pkg::CMD_QUERY) begin
                        mode_next[wp] = flash_cmd_pkg::RD_QUERY;
                    end else if (code == flash_cmd_pkg::CMD_CLEAR_STATUS) begin
                        status_next[flash_cmd_pkg::SR_ERASE_ERR] = done && op_erase_fail;
                        status_next[flash_cmd_pkg::SR_PROG_ERR] = done && op_prog_fail;
                        status_next[flash_cmd_pkg::SR_VPP_ERR] = done && op_vpp_fail;
                        status_next[flash_cmd_pkg::SR_LOCK_ERR] = done && op_lock_fail;
                    end else if (is_setup(code) && wsm_reg == flash_cmd_pkg::WSM_IDLE) begin
                        mode_next[wp] = flash_cmd_pkg::RD_STATUS;
                        unique case (code)
                            flash_cmd_pkg::CMD_PROG_SETUP,
                            flash_cmd_pkg::CMD_PROG_ALT: seq_next = flash_cmd_pkg::SEQ_PROG;
                            flash_cmd_pkg::CMD_ERASE_SETUP: seq_next = flash_cmd_pkg::SEQ_ERASE;
                            flash_cmd_pkg::CMD_LOCK_SETUP: seq_next = flash_cmd_pkg::SEQ_LOCK;
                            flash_cmd_pkg::CMD_EFP_SETUP: seq_next = flash_cmd_pkg::SEQ_EFP;
                            default: seq_next = flash_cmd_pkg::SEQ_PROT;
                        endcase
                    end
                end
                default: seq_next = flash_cmd_pkg::SEQ_IDLE;
            endcase
            // A started algorithm marks its partition busy in status read
            if (start_next) begin
                wsm_next = flash_cmd_pkg::WSM_BUSY;
                busy_part_next = wp;
                susp_erase_next = (req_next.kind == flash_cmd_pkg::OP_ERASE);
                status_next[flash_cmd_pkg::SR_READY] = 1'b0;
                mode_next[wp] = flash_cmd_pkg::RD_STATUS;
            end
            // Sequence error: erase and program error bits, status read
            if (seq_err) begin
                status_next[flash_cmd_pkg::SR_ERASE_ERR] = 1'b1;
                status_next[flash_cmd_pkg::SR_PROG_ERR] = 1'b1;
                mode_next[wp] = flash_cmd_pkg::RD_STATUS;
            end
        end
        // Presented status refreshes only on a CE or OE toggle while busy
        if (wsm_reg != flash_cmd_pkg::WSM_BUSY || ce_oe_toggle) begin
            view_next = status_next;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Registers all decoder state; reset restores defaults
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_PARTS; i++) begin
                mode_reg[i] <= flash_cmd_pkg::RD_ARRAY;
            end
            seq_reg <= flash_cmd_pkg::SEQ_IDLE;
            wsm_reg <= flash_cmd_pkg::WSM_IDLE;
            busy_part_reg <= '0;
            susp_erase_reg <= 1'b0;
            status_reg <= flash_cmd_pkg::STATUS_RESET;
            view_reg <= flash_cmd_pkg::STATUS_RESET;
            config_reg <= flash_cmd_pkg::CONFIG_RESET;
            req_reg <= '0;
            start_reg <= 1'b0;
            lact_reg <= flash_cmd_pkg::LK_NONE;
            laddr_reg <= '0;
            lstart_reg <= 1'b0;
        end else if (clk_en) begin
            mode_reg <= mode_next;
            seq_reg <= seq_next;
            wsm_reg <= wsm_next;
            busy_part_reg <= busy_part_next;
            susp_erase_reg <= susp_erase_next;
            status_reg <= status_next;
            view_reg <= view_next;
            config_reg <= config_next;
            req_reg <= req_next;
            start_reg <= start_next;
            lact_reg <= lact_next;
            laddr_reg <= laddr_next;
            lstart_reg <= lstart_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rd_mode = mode_reg[rd_part];
    assign status_view = {8'h00, view_reg};
    assign query_low_only = (mode_reg[rd_part] == flash_cmd_pkg::RD_QUERY);
    assign op_req = req_reg;
    assign op_start = start_reg;
    assign op_suspend = (wsm_reg == flash_cmd_pkg::WSM_SUSP);
    assign lock_act = lact_reg;
    assign lock_addr = laddr_reg;
    assign lock_start = lstart_reg;
    assign config_out = config_reg;
    assign efp_mode = (seq_reg == flash_cmd_pkg::SEQ_EFP_RUN);

endmodule

/* File: design/flash_cmd_pkg.sv */
// Package with command codes, status bits, modes and carrier structs of the command decoder
package flash_cmd_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_QUERY = 8'h98;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT = 8'h10;
    localparam logic [7:0] CMD_EFP_SETUP = 8'h30;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_LOCK = 8'h01;
    localparam logic [7:0] CMD_LOCK_DOWN = 8'h2f;
    localparam logic [7:0] CMD_SET_CONFIG = 8'h03;
    localparam logic [7:0] CMD_PROT_SETUP = 8'hc0;

    // ------------------------------------------------------------
    // Status register bit positions and reset values
    // ------------------------------------------------------------
    localparam int SR_READY = 7;
    localparam int SR_ERASE_SUSP = 6;
    localparam int SR_ERASE_ERR = 5;
    localparam int SR_PROG_ERR = 4;
    localparam int SR_VPP_ERR = 3;
    localparam int SR_PROG_SUSP = 2;
    localparam int SR_LOCK_ERR = 1;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam logic [15:0] CONFIG_RESET = 16'hffff;  // Async page reads selected

    // ------------------------------------------------------------
    // Per-partition read modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RD_ARRAY = 2'b00,
        RD_STATUS = 2'b01,
        RD_ID = 2'b10,
        RD_QUERY = 2'b11
    } read_mode_t;

    // Decoder sequence states
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_PROG = 3'b001,
        SEQ_ERASE = 3'b010,
        SEQ_LOCK = 3'b011,
        SEQ_EFP = 3'b100,
        SEQ_PROT = 3'b101,
        SEQ_EFP_RUN = 3'b110
    } seq_state_t;

    // Write-state-machine activity
    typedef enum logic [1:0] {
        WSM_IDLE = 2'b00,
        WSM_BUSY = 2'b01,
        WSM_SUSP = 2'b10
    } wsm_state_t;

    // Operation start kinds
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_PROGRAM = 3'b001,
        OP_ERASE = 3'b010,
        OP_EFP = 3'b011,
        OP_EFP_DATA = 3'b100,
        OP_PROT = 3'b101
    } op_kind_t;

    // Block lock actions
    typedef enum logic [1:0] {
        LK_NONE = 2'b00,
        LK_LOCK = 2'b01,
        LK_UNLOCK = 2'b10,
        LK_DOWN = 2'b11
    } lock_act_t;

    // Host write cycle as seen by the decoder
    typedef struct packed {
        logic [22:0] addr;
        logic [15:0] data;
    } bus_write_t;

    // Operation request handed to the write state machine
    typedef struct packed {
        op_kind_t kind;
        logic [22:0] addr;
        logic [15:0] data;
    } op_req_t;

endpackage

/* File: verif/flash_cmd_props.sv */
// Assertion checker for the command decoder
`timescale 1ns/1ns
module flash_cmd_props (
    input wire logic clock, // Clock
    input wire logic rst, // Reset
    input wire logic clk_en, // Run enable
    input wire logic wr_strobe, // Write strobe
    input wire flash_cmd_pkg::bus_write_t wr_bus, // Write bus
    input wire logic [15:0] status_view, // Status
    input wire flash_cmd_pkg::op_req_t op_req, // Request
    input wire logic op_start, // Start pulse
    input wire logic op_suspend, // Suspended
    input wire flash_cmd_pkg::lock_act_t lock_act, // Lock action
    input wire logic [22:0] lock_addr, // Lock address
    input wire logic lock_start, // Lock pulse
    input wire logic [15:0] config_out, // Config
    input wire logic efp_mode // Factory mode
);
    // ----------
    // Properties
    // ----------
    logic take; // Write taken
    logic [7:0] code; // Command code
    assign take = clk_en && wr_strobe;
    assign code = wr_bus.data[7:0];
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    AST_RESET_STATE: assert property (
        $fell(rst) |-> status_view == 16'h0080 && config_out == 16'hffff && !efp_mode)
        else $error("Bad reset state");
    AST_CLEAR_ERR: assert property (
        take && code == 8'h50 && status_view[7] && !op_suspend && !efp_mode
        |=> status_view[5:3] == 3'h0 && !status_view[1]) else $error("Clear failed");
    AST_EFP_DATA: assert property (
        efp_mode && take |=> op_start && op_req.kind == flash_cmd_pkg::OP_EFP_DATA)
        else $error("Bad factory data");
    AST_EFP_ENTRY: assert property (
        $rose(efp_mode) |-> op_start && op_req.kind == flash_cmd_pkg::OP_EFP)
        else $error("Bad factory entry");
    AST_LOCK_MAP: assert property (
        lock_start |-> lock_addr == $past(wr_bus.addr) && lock_act == ($past(code) == 8'h01 ?
        2'h1 : $past(code) == 8'h2f ? 2'h3 : $past(code) == 8'hd0 ? 2'h2 : 2'h0))
        else $error("Bad lock action");
    AST_CONFIG_LOAD: assert property (
        $changed(config_out) |-> $past(code) == 8'h03 && config_out == $past(wr_bus.addr[15:0]))
        else $error("Bad config load");
    AST_PROG_CAPTURE: assert property (
        op_start && op_req.kind == flash_cmd_pkg::OP_PROGRAM
        |-> op_req.addr == $past(wr_bus.addr) && op_req.data == $past(wr_bus.data))
        else $error("Bad program capture");
    AST_ERASE_CONFIRM: assert property (
        op_start && op_req.kind == flash_cmd_pkg::OP_ERASE
        |-> $past(code) == 8'hd0 && op_req.addr == $past(wr_bus.addr))
        else $error("Bad erase start");
    AST_SUSPEND_HOLD: assert property (
        op_suspend && !(take && code == 8'hd0) |=> op_suspend) else $error("Suspend dropped");
    COV_ERASE: cover property (op_start && op_req.kind == flash_cmd_pkg::OP_ERASE);
    COV_SUSPEND: cover property ($rose(op_suspend));
    COV_LOCK: cover property (lock_start);
endmodule

bind flash_command_decoder flash_cmd_props chk_u (.clock(clock), .rst(rst), .clk_en(clk_en),
    .wr_strobe(wr_strobe), .wr_bus(wr_bus), .status_view(status_view), .op_req(op_req),
    .op_start(op_start), .op_suspend(op_suspend), .lock_act(lock_act), .lock_addr(lock_addr),
    .lock_start(lock_start), .config_out(config_out), .efp_mode(efp_mode));

/* File: verif/flash_host_model.sv */
// Host processor model issuing write cycles to the decoder
`timescale 1ns/1ns
module flash_host_model (
    input wire logic clock, // Clock
    output logic wr_strobe, // Write strobe
    output flash_cmd_pkg::bus_write_t wr_bus // Write bus
);
    // ----------
    // Write cycle
    // ----------
    initial begin
        wr_strobe = 1'b0;
        wr_bus = '0;
    end
    // One write, one clock long
    task automatic wr(input logic [22:0] a, input logic [15:0] d);
        @(negedge clock);
        wr_strobe = 1'b1;
        wr_bus = {a, d};
        @(negedge clock);
        wr_strobe = 1'b0;
        wr_bus = ~wr_bus; // No stale value
    endtask
endmodule

/* File: verif/flash_command_decoder_tb.sv */
// Self-checking bench for the flash command decoder
`timescale 1ns/1ns
module flash_command_decoder_tb;
    // ----------
    // Signals and design
    // ----------
    logic clock = 1'b0, rst = 1'b1, ce_oe_toggle = 1'b0, op_done = 1'b0; // Bench inputs
    logic [2:0] rd_part = 3'h0; // Partition read
    logic wr_strobe, query_low_only, op_start, op_suspend, lock_start, efp_mode; // Flags
    flash_cmd_pkg::bus_write_t wr_bus; // Write bus
    flash_cmd_pkg::read_mode_t rd_mode; // Read mode
    logic [15:0] status_view, config_out; // Status, config
    flash_cmd_pkg::op_req_t op_req; // Request
    flash_cmd_pkg::lock_act_t lock_act; // Lock action
    logic [22:0] lock_addr; // Lock address
    int err_count = 0; // Mismatches
    int n_compared = 0; // Comparisons
    logic [9:0] rows [4] = '{{8'hff, 2'h0}, {8'h70, 2'h1}, {8'h90, 2'h2}, {8'h98, 2'h3}};
    logic [7:0] lk_code [3] = '{8'h01, 8'hd0, 8'h2f}; // Lock, unlock, lock-down
    always #2 clock = ~clock;
    flash_host_model host_u (.clock(clock), .wr_strobe(wr_strobe), .wr_bus(wr_bus));
    flash_command_decoder dut_u (.clock(clock), .rst(rst), .clk_en(1'b1), .wr_strobe(wr_strobe),
        .wr_bus(wr_bus), .ce_oe_toggle(ce_oe_toggle), .op_done(op_done), .op_prog_fail(1'b0),
        .op_erase_fail(1'b0), .op_vpp_fail(op_done), .op_lock_fail(1'b0), .rd_part(rd_part),
        .rd_mode(rd_mode), .status_view(status_view), .query_low_only(query_low_only),
        .op_req(op_req), .op_start(op_start), .op_suspend(op_suspend), .lock_act(lock_act),
        .lock_addr(lock_addr), .lock_start(lock_start), .config_out(config_out),
        .efp_mode(efp_mode));
    // Compare one value and count it
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle pulse on a control input
    task automatic pulse(ref logic s);
        @(negedge clock);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask
    task automatic test_done();
        $display("compared=%0d errors=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ----------
    // Scenarios
    // ----------
    initial begin
        repeat (3) @(negedge clock);
        rst = 1'b0;
        chk({rd_mode, status_view, config_out}, {2'h0, 16'h0080, 16'hffff});
        // Read mode table, one partition per row
        foreach (rows[i]) begin
            rd_part = i[2:0];
            host_u.wr({i[2:0], 20'h0}, {8'h00, rows[i][9:2]});
            chk({rd_mode, query_low_only}, {rows[i][1:0], rows[i][1:0] == 2'h3});
        end
        // Erase, suspend, resume
        rd_part = 3'h5;
        host_u.wr(23'h500000, 16'h0020);
        chk(rd_mode, 2'h1);
        host_u.wr(23'h512345, 16'h00d0);
        chk({op_start, op_req.kind, op_req.addr}, {1'b1, 3'h2, 23'h512345});
        host_u.wr(23'h500000, 16'h0090);
        chk(rd_mode, 2'h1);
        host_u.wr(23'h000000, 16'h00b0);
        chk(status_view[7], 1'b0);
        pulse(ce_oe_toggle);
        chk({op_suspend, status_view[7:6], status_view[2]}, {1'b1, 2'h3, 1'b0});
        pulse(op_done);
        chk(op_suspend, 1'b1);
        host_u.wr(23'h7fffff, 16'h00d0);
        chk(op_suspend, 1'b0);
        pulse(op_done);
        // Program via 10h
        rd_part = 3'h2;
        host_u.wr(23'h200010, 16'h0010);
        host_u.wr(23'h200010, 16'hbeef);
        chk({op_start, op_req}, {1'b1, 3'h1, 23'h200010, 16'hbeef});
        pulse(op_done);
        @(negedge clock);
        chk({rd_mode, status_view[7], status_view[3]}, {2'h1, 2'h3});
        host_u.wr(23'h200000, 16'h00ff);
        chk(rd_mode, 2'h0);
        // Broken sequences, then clear
        rd_part = 3'h5;
        host_u.wr(23'h500000, 16'h0020);
        host_u.wr(23'h500000, 16'h00ff);
        chk({status_view[5:4], rd_mode}, {2'h3, 2'h1});
        host_u.wr(23'h000000, 16'h0050);
        chk(status_view[5:4], 2'h0);
        host_u.wr(23'h300000, 16'h0060);
        host_u.wr(23'h300000, 16'h0090);
        chk(status_view[5:4], 2'h3);
        host_u.wr(23'h000000, 16'h0050);
        foreach (lk_code[k]) begin
            host_u.wr(23'h3abcde, 16'h0060);
            host_u.wr(23'h3abcde, {8'h00, lk_code[k]});
            chk({lock_start, lock_act, lock_addr}, {1'b1, k[1:0] + 2'h1, 23'h3abcde});
        end
        rd_part = 3'h0;
        host_u.wr(23'h04a5c3, 16'h0060);
        host_u.wr(23'h04a5c3, 16'h0003);
        chk({config_out, rd_mode}, {16'ha5c3, 2'h0});
        // Factory program mode
        host_u.wr(23'h600000, 16'h0030);
        host_u.wr(23'h600000, 16'h00d0);
        chk({efp_mode, op_req.kind}, {1'b1, 3'h3});
        host_u.wr(23'h600004, 16'h0070);
        chk({op_start, op_req.kind, op_req.data}, {1'b1, 3'h4, 16'h0070});
        pulse(op_done);
        // Reset after the factory run ends
        rst = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        chk({config_out, status_view, efp_mode}, {16'hffff, 16'h0080, 1'b0});
        test_done();
    end
    // Watchdog
    initial begin
        #20000;
        err_count++;
        test_done();
    end
endmodule
